// ### earth_fault_defs.vh
// constants of the earth fault pick-up stage: apb map, fields, resets, timing
`ifndef EARTH_FAULT_DEFS_VH
`define EARTH_FAULT_DEFS_VH

// apb byte offsets
`define EF_OFF_CTRL      12'h000
`define EF_OFF_PICKUP    12'h004
`define EF_OFF_HARMLIM   12'h008
`define EF_OFF_OPDELAY   12'h00C
`define EF_OFF_STATUS    12'h010
`define EF_OFF_ANGLE     12'h014
`define EF_OFF_EXPECT    12'h018
`define EF_OFF_REMAIN    12'h01C
`define EF_OFF_RATIO     12'h020
`define EF_OFF_SNAPCUR   12'h024

// control register fields
`define EF_CTRL_INRUSH   0
`define EF_CTRL_IDMT     1
`define EF_CTRL_SEL_LO   2
`define EF_CTRL_SEL_HI   3
`define EF_CTRL_LN_LO    4
`define EF_CTRL_LN_HI    6

// reset values
`define EF_RST_PICKUP    24'h00_2EE0
`define EF_RST_HARMLIM   16'h0001
`define EF_RST_OPDELAY   19'h0_0014
`define EF_RST_SEL       2'h1
`define EF_RST_LN        3'h1
`define EF_RST_INRUSH    1'h0

// input source codes
`define EF_SEL_COARSE    2'h1
`define EF_SEL_SENS      2'h2
`define EF_SEL_CALC      2'h3

// stage condition codes
`define EF_COND_NORMAL   2'h0
`define EF_COND_START    2'h1
`define EF_COND_TRIP     2'h2
`define EF_COND_BLOCKED  2'h3

// logical node behaviour codes
`define EF_LN_ON         3'h1
`define EF_LN_BLOCKED    3'h2
`define EF_LN_TEST       3'h3
`define EF_LN_TESTBLK    3'h4
`define EF_LN_OFF        3'h5

// hysteresis and timing
`define EF_RESET_PCT     7'h61
`define EF_FULL_PCT      7'h64
`define EF_CYCLE_NS      5000000
`define EF_CLOCK_NS      4
`define EF_CYCLE_CLKS    (`EF_CYCLE_NS / `EF_CLOCK_NS)
`define EF_MAX_STEPS     19'h5_7E40
`define EF_ANGLE_FULL    17'h0_8CA0

`endif

// ### earth_fault_stage.v
// earth fault stage: pick-up, blocking, status read-outs, apb registers
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "earth_fault_defs.vh"

// Functional notes
// - pick up when measured magnitude exceeds the pick-up level
// - release pick-up only below 97 percent of the pick-up level
// - one pick-up level, 0.0001 In steps, default 1.20 In
// - start only while picked up and not blocked
// - block input sampled once at program cycle start, held all cycle
// - block is external input, blocked behaviour mode or optional inrush harmonic block
// - inrush enable defaults off; harmonic limit in 0.01 percent steps
// - pick-up during block gives blocked, no timing
// - block during start drops start and releases like pick-up loss
// - entering blocked gives display note and block event with snapshot
// - start without block begins operate timing, definite or inverse
// - condition code 0 normal, 1 start, 2 trip, 3 blocked
// - previous fault type and direction reported as code 0 to 6
// - residual angle in 0.01 deg against voltage or current reference
// - expected operate time in 5 ms steps, tracks current in inverse
// - remaining time to trip in 5 ms steps, up to 1800 s
// - ratio of measured current to pick-up level, 0.01 steps
// - logical node behaviour code 1 on to 5 off
// - source coarse, sensitive or calculated, default coarse
// - residual inputs refreshed on a 5 ms time base
module earth_fault_stage #(
    parameter CYCLE_CLKS = `EF_CYCLE_CLKS,
    parameter MAG_W      = 24
) (
    // clock and reset
    input  wire              clock,
    input  wire              rstn,
    // apb slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [11:0]       paddr,
    input  wire [31:0]       pwdata,
    output wire              pready,
    output reg  [31:0]       prdata,
    output wire              pslverr,
    // measurement front end, same clock
    input  wire [MAG_W-1:0]  coarseResidual,
    input  wire [MAG_W-1:0]  sensitiveResidual,
    input  wire [MAG_W-1:0]  calculatedResidual,
    input  wire [15:0]       harmonicRatio,
    input  wire [15:0]       residualAngle,
    input  wire [15:0]       voltageRefAngle,
    input  wire [15:0]       currentRefAngle,
    input  wire              voltagesPresent,
    input  wire [2:0]        faultTypeIn,
    input  wire [18:0]       inverseTime,
    // blocking matrix pin, asynchronous
    input  wire              blockInput,
    // stage outputs
    output reg               pickup,
    output reg               start,
    output reg               trip,
    output reg               blocked,
    output reg               cycleTick,
    output reg               blockEvent,
    output reg               displayNote
);

    // apb decode
    // writes land on the access edge
    wire        wrEn = psel & penable & pwrite;
    wire        rdEn = psel & penable & ~pwrite;
    reg         hit;

    // settings
    reg [MAG_W-1:0] pickupLevel;
    reg [15:0]      harmLimit;
    reg [18:0]      opDelay;
    reg             inrushEn;
    reg             idmtMode;
    reg [1:0]       inputSel;
    reg [2:0]       lnMode;

    // state
    reg [31:0]      cycleCount;
    reg [2:0]       blockSync;
    reg             blockClean;
    reg             blockSampled;
    reg [MAG_W-1:0] measuredMagnitude;
    reg [18:0]      remaining;
    reg [18:0]      expected;
    reg [1:0]       condition;
    reg [2:0]       faultType;

    // 17 bits to span +-360.00 deg
    reg [16:0]      angleOut;
    reg [MAG_W-1:0] snapCurrent;
    reg [2:0]       snapFault;
    reg [15:0]      ratio;

    // divider for the ratio read-out
    reg [MAG_W+6:0] divRem;
    reg [MAG_W+6:0] divQuo;
    reg [5:0]       divStep;
    reg             divBusy;

    // comb terms
    reg [MAG_W-1:0] next_mag;
    reg [16:0]      angleDiff;

    // drop-off test as mag*100 < level*97
    wire [MAG_W+6:0] magScaled = {7'h00, measuredMagnitude} * `EF_FULL_PCT;
    wire [MAG_W+6:0] lvlScaled = {7'h00, pickupLevel} * `EF_RESET_PCT;
    wire [MAG_W+6:0] divTrial  = {divRem[MAG_W+5:0], divQuo[MAG_W+6]};
    // off mode mutes all; blocked modes force a block
    wire             lnOff     = (lnMode == `EF_LN_OFF);
    wire             lnBlock   = (lnMode == `EF_LN_BLOCKED) |
                                 (lnMode == `EF_LN_TESTBLK);
    wire             inrushBlk = inrushEn & (harmonicRatio > harmLimit);
    wire             blockNow  = blockSampled | inrushBlk | lnBlock;

    // no wait states; error on unmapped offsets
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // source selection, each input already on the 5 ms refresh
    always @* begin
        case (inputSel)
            `EF_SEL_SENS: next_mag = sensitiveResidual;
            `EF_SEL_CALC: next_mag = calculatedResidual;
            default:      next_mag = coarseResidual;
        endcase
    end

    // angle against the chosen reference, wrapped into +-360 deg
    always @* begin
        angleDiff = {residualAngle[15], residualAngle} -
                    (voltagesPresent ? {voltageRefAngle[15], voltageRefAngle}
                                     : {currentRefAngle[15], currentRefAngle});
        if (!angleDiff[16] && angleDiff > `EF_ANGLE_FULL) begin
            angleDiff = angleDiff - `EF_ANGLE_FULL;
        end else if (angleDiff[16] && (17'h0 - angleDiff) > `EF_ANGLE_FULL)
        begin
            angleDiff = angleDiff + `EF_ANGLE_FULL;
        end
    end

    // address hit check
    always @* begin
        case (paddr)
            `EF_OFF_CTRL, `EF_OFF_PICKUP, `EF_OFF_HARMLIM,
            `EF_OFF_OPDELAY, `EF_OFF_STATUS, `EF_OFF_ANGLE,
            `EF_OFF_EXPECT, `EF_OFF_REMAIN, `EF_OFF_RATIO,
            `EF_OFF_SNAPCUR: hit = 1'b1;
            default:         hit = 1'b0;
        endcase
    end

    // settings written over apb
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pickupLevel <= `EF_RST_PICKUP;
            harmLimit   <= `EF_RST_HARMLIM;
            opDelay     <= `EF_RST_OPDELAY;
            inrushEn    <= `EF_RST_INRUSH;
            idmtMode    <= 1'b0;
            inputSel    <= `EF_RST_SEL;
            lnMode      <= `EF_RST_LN;
        end else if (wrEn) begin
            case (paddr)
                `EF_OFF_CTRL: begin
                    inrushEn <= pwdata[`EF_CTRL_INRUSH];
                    idmtMode <= pwdata[`EF_CTRL_IDMT];
                    // zero or unknown codes keep the old value
                    if (pwdata[`EF_CTRL_SEL_HI:`EF_CTRL_SEL_LO] != 2'h0) begin
                        inputSel <= pwdata[`EF_CTRL_SEL_HI:`EF_CTRL_SEL_LO];
                    end
                    if (pwdata[`EF_CTRL_LN_HI:`EF_CTRL_LN_LO] != 3'h0 &&
                        pwdata[`EF_CTRL_LN_HI:`EF_CTRL_LN_LO] <= `EF_LN_OFF)
                    begin
                        lnMode <= pwdata[`EF_CTRL_LN_HI:`EF_CTRL_LN_LO];
                    end
                end
                `EF_OFF_PICKUP:  pickupLevel <= pwdata[MAG_W-1:0];
                `EF_OFF_HARMLIM: harmLimit   <= pwdata[15:0];
                `EF_OFF_OPDELAY: opDelay     <= pwdata[18:0];
                default: ;
            endcase
        end
    end

    // read mux, registered data out
    // set at setup, stands through the access
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            case (paddr)
                `EF_OFF_CTRL:    prdata <= {25'h0, lnMode, inputSel,
                                            idmtMode, inrushEn};
                `EF_OFF_PICKUP:  prdata <= {{(32-MAG_W){1'b0}}, pickupLevel};
                `EF_OFF_HARMLIM: prdata <= {16'h0000, harmLimit};
                `EF_OFF_OPDELAY: prdata <= {13'h0000, opDelay};
                `EF_OFF_STATUS:  prdata <= {16'h0000, blocked, trip, start,
                                            pickup, 1'b0, lnMode,
                                            1'b0, faultType,
                                            2'h0, condition};
                `EF_OFF_ANGLE:   prdata <= {{15{angleOut[16]}}, angleOut};
                `EF_OFF_EXPECT:  prdata <= {13'h0000, expected};
                `EF_OFF_REMAIN:  prdata <= {13'h0000, remaining};
                `EF_OFF_RATIO:   prdata <= {16'h0000, ratio};
                `EF_OFF_SNAPCUR: prdata <= {snapFault, 5'h00, snapCurrent};
                default:         prdata <= 32'h0000_0000;
            endcase
        end
    end

    // block pin: three flops, change accepted when last two agree
    // pulses under two clocks may be lost
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            blockSync  <= 3'h0;
            blockClean <= 1'b0;
        end else begin
            blockSync <= {blockSync[1:0], blockInput};
            if (blockSync[1] == blockSync[2]) begin
                blockClean <= blockSync[2];
            end
        end
    end

    // program cycle base, one tick per 5 ms
    // 32-bit count so the 5 ms default fits
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cycleCount <= 32'h0000_0000;
            cycleTick  <= 1'b0;
        end else if (cycleCount >= CYCLE_CLKS - 1) begin
            cycleCount <= 32'h0000_0000;
            cycleTick  <= 1'b1;
        end else begin
            cycleCount <= cycleCount + 32'h0000_0001;
            cycleTick  <= 1'b0;
        end
    end

    // sample inputs at the start of each program cycle
    // held all cycle: decisions see one snapshot
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            blockSampled      <= 1'b0;
            measuredMagnitude <= {MAG_W{1'b0}};
            angleOut          <= 17'h0_0000;
        end else if (cycleTick) begin
            blockSampled      <= blockClean;
            measuredMagnitude <= next_mag;
            angleOut          <= angleDiff;
        end
    end

    // pick-up with hysteresis and the stage outputs, one step per cycle;
    // decisions run one clock after sampling so they see the held values
    reg tickLate;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tickLate    <= 1'b0;
            pickup      <= 1'b0;
            start       <= 1'b0;
            trip        <= 1'b0;
            blocked     <= 1'b0;
            condition   <= `EF_COND_NORMAL;
            remaining   <= 19'h0_0000;
            expected    <= 19'h0_0000;
            faultType   <= 3'h0;
            snapCurrent <= {MAG_W{1'b0}};
            snapFault   <= 3'h0;
            blockEvent  <= 1'b0;
            displayNote <= 1'b0;
        end else begin
            tickLate    <= cycleTick;
            blockEvent  <= 1'b0;
            displayNote <= 1'b0;
            if (tickLate) begin
                // expected operate time, inverse tracks current each cycle
                expected <= idmtMode ? inverseTime : opDelay;

                // 97 percent drop-off once picked up
                if (lnOff) begin
                    pickup <= 1'b0;
                end else if (!pickup) begin
                    pickup <= measuredMagnitude > pickupLevel;
                end else begin
                    pickup <= !(magScaled < lvlScaled);
                end

                if (pickup && blockNow && !lnOff) begin
                    // block wins, timing abandoned
                    start     <= 1'b0;
                    trip      <= 1'b0;
                    remaining <= 19'h0_0000;
                    blocked   <= 1'b1;
                    condition <= `EF_COND_BLOCKED;
                    if (!blocked) begin
                        blockEvent  <= 1'b1;
                        displayNote <= 1'b1;
                        snapCurrent <= measuredMagnitude;
                        snapFault   <= faultTypeIn;
                    end
                end else if (pickup && !lnOff) begin
                    blocked <= 1'b0;
                    start   <= 1'b1;
                    if (!start) begin
                        // fresh start loads the operate time
                        remaining <= idmtMode ? inverseTime : opDelay;
                        condition <= `EF_COND_START;
                        faultType <= faultTypeIn;
                    end else if (remaining > 19'h0_0001) begin
                        remaining <= remaining - 19'h0_0001;
                        condition <= `EF_COND_START;
                    end else begin
                        remaining <= 19'h0_0000;
                        trip      <= 1'b1;
                        condition <= `EF_COND_TRIP;
                    end
                end else begin
                    // release: timing cleared, as after pick-up loss
                    start     <= 1'b0;
                    trip      <= 1'b0;
                    blocked   <= 1'b0;
                    remaining <= 19'h0_0000;
                    condition <= `EF_COND_NORMAL;
                end
            end

            // long inverse times held at 1800 s
            if (remaining > `EF_MAX_STEPS) begin
                remaining <= `EF_MAX_STEPS;
            end
        end
    end

    // ratio in hundredths: restoring divide of magnitude*100 by level;
    // serial to save a wide divider, done well inside one cycle
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            divRem  <= {(MAG_W+7){1'b0}};
            divQuo  <= {(MAG_W+7){1'b0}};
            divStep <= 6'h00;
            divBusy <= 1'b0;
            ratio   <= 16'h0000;
        end else if (tickLate && !divBusy) begin
            divRem  <= {(MAG_W+7){1'b0}};
            divQuo  <= magScaled;
            divStep <= 6'h00;
            divBusy <= (pickupLevel != {MAG_W{1'b0}});
        end else if (divBusy) begin
            // one quotient bit per clock, msb first
            if (divTrial >= {7'h00, pickupLevel}) begin
                divRem <= divTrial - {7'h00, pickupLevel};
                divQuo <= {divQuo[MAG_W+5:0], 1'b1};
            end else begin
                divRem <= divTrial;
                divQuo <= {divQuo[MAG_W+5:0], 1'b0};
            end
            if (divStep == MAG_W + 6) begin
                divBusy <= 1'b0;
            end
            divStep <= divStep + 6'h01;
        end else if (divStep == MAG_W + 7) begin
            // saturate to the 16-bit read-out
            ratio   <= (divQuo[MAG_W+6:16] != 0) ? 16'hFFFF
                                                 : divQuo[15:0];
            divStep <= 6'h00;
        end
    end

endmodule // earth_fault_stage

// ### earth_fault_stage_sva.sv
// checker: timing and handshake relations at the stage ports
`timescale 1ns/100ps
module earth_fault_stage_sva #(
    parameter CYCLE_CLKS = 50
) (
    // clock and reset
    input wire clock,
    input wire rstn,
    // apb
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    // stage
    input wire pickup,
    input wire start,
    input wire trip,
    input wire blocked,
    input wire cycleTick,
    input wire blockEvent,
    input wire displayNote
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // clocks since last tick; first period is not judged
    reg [31:0] gap;
    reg        seen;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            gap  <= 32'h0000_0000;
            seen <= 1'b0;
        end else begin
            gap  <= cycleTick ? 32'h0000_0001 : gap + 32'h0000_0001;
            seen <= seen | cycleTick;
        end
    end

    chk_tick_period: assert property (cycleTick && seen |-> gap == CYCLE_CLKS)
        else $error("program cycle spacing wrong");
    chk_zero_wait: assert property (psel && penable |-> pready)
        else $error("apb access not answered");
    chk_err_phase: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
    chk_start_clear: assert property (start |-> !blocked)
        else $error("start while blocked");
    chk_start_cause: assert property ($rose(start) |-> $past(pickup))
        else $error("start without prior pickup");
    chk_level_moment: assert property ($changed(start) || $changed(pickup)
        || $changed(blocked) |-> $past(cycleTick, 2))
        else $error("stage level moved off the decision edge");
    chk_event_pair: assert property (blockEvent == displayNote)
        else $error("block event and display note differ");
    chk_event_entry: assert property ($rose(blocked) |-> ##[0:1] blockEvent)
        else $error("no block event on entering blocked");
    chk_event_pulse: assert property (blockEvent |=> !blockEvent)
        else $error("block event longer than one clock");
    chk_trip_cause: assert property ($rose(trip) |-> $past(start) && !blocked)
        else $error("trip without running start");

    cover property ($rose(start));
    cover property ($rose(trip));
    cover property (blockEvent);
    cover property (pslverr);
endmodule // earth_fault_stage_sva

bind earth_fault_stage earth_fault_stage_sva #(.CYCLE_CLKS(CYCLE_CLKS)) chk (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .pickup(pickup), .start(start),
    .trip(trip), .blocked(blocked), .cycleTick(cycleTick),
    .blockEvent(blockEvent), .displayNote(displayNote));

// ### residual_front_end.sv
// model of the measurement front end feeding residual magnitudes
`timescale 1ns/100ps
module residual_front_end (
    // clock and reset
    input  wire        clock,
    input  wire        rstn,
    // program cycle strobe and bench targets
    input  wire        cycleTick,
    input  wire [23:0] setMag,
    input  wire [15:0] setHarm,
    // measured values toward the stage
    output reg  [23:0] coarseResidual,
    output reg  [23:0] sensitiveResidual,
    output reg  [23:0] calculatedResidual,
    output reg  [15:0] harmonicRatio
);
    // fresh values once per program cycle, never in between
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            coarseResidual     <= 24'h00_0000;
            sensitiveResidual  <= 24'h00_0000;
            calculatedResidual <= 24'h00_0000;
            harmonicRatio      <= 16'h0000;
        end else if (cycleTick) begin
            coarseResidual     <= setMag;
            sensitiveResidual  <= setMag >> 1; // distinct so source shows
            calculatedResidual <= setMag << 1;
            harmonicRatio      <= setHarm;
        end
    end
endmodule // residual_front_end

// ### earth_fault_stage_bench.sv
// self-checking bench for the earth fault stage over apb
`timescale 1ns/100ps
`include "earth_fault_defs.vh"
module earth_fault_stage_bench;
    localparam CYC = 50;
    reg         clock, rstn, psel, penable, pwrite, blockInput;
    reg         voltagesPresent;
    reg  [11:0] paddr;
    reg  [31:0] pwdata;
    reg  [23:0] setMag;
    reg  [15:0] setHarm, residualAngle, voltageRefAngle, currentRefAngle;
    reg  [2:0]  faultTypeIn;
    reg  [18:0] inverseTime;
    wire        pready, pslverr, pickup, start, trip, blocked;
    wire        cycleTick, blockEvent, displayNote;
    wire [31:0] prdata;
    wire [23:0] coarse, sens, calc;
    wire [15:0] harm;
    integer     err_total, checks, seed, events, k, ang;
    reg  [64:0] notes[$];
    reg  [64:0] note;

    earth_fault_stage #(.CYCLE_CLKS(CYC)) dut (
        .clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .coarseResidual(coarse),
        .sensitiveResidual(sens), .calculatedResidual(calc),
        .harmonicRatio(harm), .residualAngle(residualAngle),
        .voltageRefAngle(voltageRefAngle),
        .currentRefAngle(currentRefAngle),
        .voltagesPresent(voltagesPresent), .faultTypeIn(faultTypeIn),
        .inverseTime(inverseTime), .blockInput(blockInput),
        .pickup(pickup), .start(start), .trip(trip), .blocked(blocked),
        .cycleTick(cycleTick), .blockEvent(blockEvent),
        .displayNote(displayNote));
    residual_front_end fe (
        .clock(clock), .rstn(rstn), .cycleTick(cycleTick),
        .setMag(setMag), .setHarm(setHarm), .coarseResidual(coarse),
        .sensitiveResidual(sens), .calculatedResidual(calc),
        .harmonicRatio(harm));

    // free-running 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task bad(input string msg);
        err_total = err_total + 1;
        $display("BAD %0t %0s", $time, msg);
    endtask

    task test_done;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one apb transfer; a read leaves its expectation in the queue
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
             input logic [31:0] m, input logic e);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        if (!wr) notes.push_back({e, m, d});
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // settle past n program cycle decisions
    task ticks(input integer n);
        repeat (n) begin
            @(posedge clock);
            while (cycleTick !== 1'b1) @(posedge clock);
        end
        repeat (4) @(posedge clock);
    endtask

    task ev(input integer n);
        checks = checks + 1;
        if (events != n) bad("block event count");
    endtask

    // reads are judged against the oldest note as their data lands
    always @(posedge clock) begin
        if (blockEvent === 1'b1) events = events + 1;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            note = notes.pop_front();
            checks = checks + 1;
            if ((prdata & note[63:32]) !== note[31:0] || pslverr !== note[64])
                bad("read mismatch");
        end
    end

    // hang guard, well past the planned run
    initial begin
        #(CYC * 4 * 200);
        err_total = err_total + 1;
        test_done;
    end

    initial begin
        seed = 1;
        err_total = 0;
        checks = 0;
        events = 0;
        {rstn, psel, penable, pwrite, blockInput} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        setMag = 24'h00_0000;
        setHarm = 16'h0000;
        voltagesPresent = $random(seed);
        residualAngle = $random(seed);
        voltageRefAngle = $random(seed);
        currentRefAngle = $random(seed);
        inverseTime = $random(seed);
        faultTypeIn = 3'h1 + ($unsigned($random(seed)) % 6);
        ang = $signed(residualAngle) - (voltagesPresent ?
            $signed(voltageRefAngle) : $signed(currentRefAngle));
        if (ang > 36000) ang = ang - 36000;
        if (ang < -36000) ang = ang + 36000;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        apb(0, `EF_OFF_CTRL, 32'h0000_0014, 32'h0000_007F, 0);
        apb(0, `EF_OFF_PICKUP, 32'h0000_2EE0, 32'h00FF_FFFF, 0);
        apb(0, `EF_OFF_HARMLIM, 32'h0000_0001, 32'h0000_FFFF, 0);
        apb(0, `EF_OFF_STATUS, 32'h0000_0100, 32'h0000_F773, 0);
        apb(0, 12'h040, 32'h0000_0000, 32'hFFFF_FFFF, 1);
        $display("test reset values done");
        apb(1, `EF_OFF_PICKUP, 32'h0000_03E8, 32'h0000_0000, 0);
        apb(1, `EF_OFF_OPDELAY, 32'h0000_0008, 32'h0000_0000, 0);
        setMag <= 24'h00_03E8;
        ticks(4);
        apb(0, `EF_OFF_STATUS, 32'h0000_0000, 32'h0000_3003, 0);
        setMag <= 24'h00_03E9;
        ticks(4);
        apb(0, `EF_OFF_STATUS, 32'h0000_3001 | (faultTypeIn << 4),
            32'h0000_3073, 0);
        apb(0, `EF_OFF_REMAIN, 32'h0000_0007, 32'h0007_FFFF, 0);
        apb(0, `EF_OFF_ANGLE, ang, 32'hFFFF_FFFF, 0);
        repeat (40) @(posedge clock);
        apb(0, `EF_OFF_RATIO, 32'h0000_0064, 32'h0000_FFFF, 0);
        apb(0, `EF_OFF_EXPECT, 32'h0000_0008, 32'h0007_FFFF, 0);
        ticks(10);
        apb(0, `EF_OFF_STATUS, 32'h0000_4002, 32'h0000_4003, 0);
        $display("test pickup and trip done");
        setMag <= 24'h00_03CA;
        ticks(4);
        apb(0, `EF_OFF_STATUS, 32'h0000_1000, 32'h0000_1000, 0);
        setMag <= 24'h00_03C9;
        ticks(4);
        apb(0, `EF_OFF_STATUS, 32'h0000_0000, 32'h0000_7003, 0);
        $display("test hysteresis done");
        blockInput <= 1'b1;
        setMag <= 24'h00_03E9;
        ticks(4);
        apb(0, `EF_OFF_STATUS, 32'h0000_9003,
            32'h0000_B003, 0);
        ev(1);
        blockInput <= 1'b0;
        ticks(2);
        apb(0, `EF_OFF_STATUS, 32'h0000_3001, 32'h0000_B003, 0);
        blockInput <= 1'b1;
        ticks(3);
        apb(0, `EF_OFF_STATUS, 32'h0000_9003, 32'h0000_B003, 0);
        ev(2);
        blockInput <= 1'b0;
        setMag <= 24'h00_0000;
        ticks(4);
        $display("test blocking done");
        apb(1, `EF_OFF_CTRL, 32'h0000_0015, 32'h0000_0000, 0);
        apb(1, `EF_OFF_HARMLIM, 32'h0000_01F4, 32'h0000_0000, 0);
        setHarm <= 16'h01F5;
        setMag <= 24'h00_03E9;
        ticks(4);
        apb(0, `EF_OFF_STATUS, 32'h0000_9003, 32'h0000_B003, 0);
        setHarm <= 16'h01F4;
        ticks(3);
        apb(0, `EF_OFF_STATUS, 32'h0000_3001, 32'h0000_B003, 0);
        setMag <= 24'h00_0258;
        apb(1, `EF_OFF_CTRL, 32'h0000_001C, 32'h0000_0000, 0);
        ticks(4);
        apb(0, `EF_OFF_STATUS, 32'h0000_1000, 32'h0000_1000, 0);
        apb(1, `EF_OFF_CTRL, 32'h0000_0018, 32'h0000_0000, 0);
        ticks(4);
        apb(0, `EF_OFF_STATUS, 32'h0000_0000, 32'h0000_1000, 0);
        $display("test inrush and source done");
        setMag <= 24'h00_0000;
        ticks(4);
        for (k = 1; k <= 5; k = k + 1) begin
            apb(1, `EF_OFF_CTRL, 32'h0000_0004 | (k << 4), 32'h0000_0000, 0);
            apb(0, `EF_OFF_CTRL, 32'h0000_0004 | (k << 4),
                32'h0000_007F, 0);
        end
        apb(1, `EF_OFF_CTRL, 32'h0000_0074, 32'h0000_0000, 0);
        apb(0, `EF_OFF_CTRL, 32'h0000_0054, 32'h0000_007F, 0);
        apb(0, `EF_OFF_STATUS, 32'h0000_0500, 32'h0000_F703, 0);
        inverseTime <= $random(seed);
        apb(1, `EF_OFF_CTRL, 32'h0000_0056, 32'h0000_0000, 0);
        ticks(1);
        apb(0, `EF_OFF_EXPECT, inverseTime, 32'h0007_FFFF, 0);
        $display("test behaviour codes done");
        test_done;
    end
endmodule // earth_fault_stage_bench
